// ---- include/aod_pkg.sv ----
// Encodings, enumerations and clock figures shared by the arithmetic opcode decoder
package aod_pkg;

	// Decoded operation class
	typedef enum logic [3:0] {
		OP_NONE, OP_SEG, OP_SUM, OP_CSUM, OP_DIFF, OP_BDIFF, OP_COMPARE,
		OP_UP, OP_DOWN, OP_SIGN, OP_PROD, OP_AFIX_S, OP_BFIX_S, OP_AFIX_D, OP_BFIX_D
	} aod_op_t;

	// Operand form
	typedef enum logic [2:0] {F_NONE, F_RM, F_IMM, F_ACC, F_ONE} aod_form_t;

	// Segment chosen by an override prefix
	typedef enum logic [1:0] {SEG_CODE, SEG_STACK, SEG_DATA, SEG_EXTRA} aod_seg_t;

	// Opcode family that owns the selector field
	typedef enum logic [1:0] {G_ALU, G_IMM, G_UNARY, G_STEP} aod_grp_t;

	// One-byte opcodes
	localparam logic [7:0] PFX_CODE = 8'h2E;
	localparam logic [7:0] PFX_STACK = 8'h36;
	localparam logic [7:0] PFX_DATA = 8'h3E;
	localparam logic [7:0] PFX_EXTRA = 8'h26;
	localparam logic [7:0] FIX_ASCII_SUM = 8'h37;
	localparam logic [7:0] FIX_BCD_SUM = 8'h27;
	localparam logic [7:0] FIX_ASCII_DIF = 8'h3F;
	localparam logic [7:0] FIX_BCD_DIF = 8'h2F;

	// Opcode family patterns
	localparam logic [5:0] IMM_GRP = 6'h20;
	localparam logic [6:0] UNARY_GRP = 7'h7B;
	localparam logic [6:0] STEP_GRP = 7'h7F;
	localparam logic [3:0] SHORT_STEP = 4'h4;

	// Selector field values
	localparam logic [2:0] SEL_SUM = 3'h0;
	localparam logic [2:0] SEL_CSUM = 3'h2;
	localparam logic [2:0] SEL_BDIFF = 3'h3;
	localparam logic [2:0] SEL_DIFF = 3'h5;
	localparam logic [2:0] SEL_COMPARE = 3'h7;
	localparam logic [2:0] SEL_UP = 3'h0;
	localparam logic [2:0] SEL_DOWN = 3'h1;
	localparam logic [2:0] SEL_SIGN = 3'h3;
	localparam logic [2:0] SEL_PROD = 3'h4;

	// Operand selector byte modes
	localparam logic [1:0] MOD_IND = 2'h0;
	localparam logic [1:0] MOD_D8 = 2'h1;
	localparam logic [1:0] MOD_D16 = 2'h2;
	localparam logic [1:0] MOD_REG = 2'h3;
	localparam logic [2:0] RM_DIRECT = 3'h6;

	// Execution clock counts
	localparam logic [7:0] C_PFX = 8'h02;
	localparam logic [7:0] C_RR = 8'h03;
	localparam logic [7:0] C_RM = 8'h0A;
	localparam logic [7:0] C_IR = 8'h04;
	localparam logic [7:0] C_IM = 8'h10;
	localparam logic [7:0] C_AB = 8'h03;
	localparam logic [7:0] C_AW = 8'h04;
	localparam logic [7:0] C_STEP_R = 8'h03;
	localparam logic [7:0] C_STEP_M = 8'h0F;
	localparam logic [7:0] C_PRB = 8'h1C;
	localparam logic [7:0] C_PRW = 8'h25;
	localparam logic [7:0] C_PMB = 8'h22;
	localparam logic [7:0] C_PMW = 8'h2B;
	localparam logic [7:0] C_ASUM = 8'h08;
	localparam logic [7:0] C_BSUM = 8'h04;
	localparam logic [7:0] C_ADIF = 8'h07;
	localparam logic [7:0] C_BDIF = 8'h04;
	localparam logic [7:0] C_WX = 8'h04;
	localparam logic [7:0] C_BAD = 8'h02;
	localparam logic [7:0] C_MIN = 8'h02;

endpackage : aod_pkg

// ---- logic/aod_decoder.sv ----
// Arithmetic opcode decoder fed from the prefetch queue
`timescale 1ns/10ps
module aod_decoder #(
	parameter bit NARROW_BUS = 1'b0 // 8-bit bus variant
) (
	input wire logic clock, // 20 MHz processor clock
	input wire logic arst_n, // Asynchronous reset
	input wire logic q_valid, // Queue offers a byte
	input wire logic [7:0] q_byte, // Queue byte
	output logic q_ready, // Decoder takes the byte
	output logic done, // Instruction finished
	output aod_pkg::aod_op_t op, // Operation class
	output aod_pkg::aod_form_t form, // Operand form
	output logic width, // Word operand
	output logic dir_s, // Direction or sign bit
	output logic mem, // Memory operand
	output logic [2:0] sel, // Selector field
	output logic [2:0] rm, // Register/memory field
	output logic [15:0] imm, // Immediate value
	output logic [7:0] clocks, // Execution clocks
	output logic seg_valid, // Override applies
	output aod_pkg::aod_seg_t seg, // Overriding segment
	output logic writes, // Result written back
	output logic bad // Opcode not handled
);

	typedef enum logic [2:0] {ST_OPC, ST_MODRM, ST_DLO, ST_DHI, ST_ILO, ST_IHI, ST_EXEC} aod_st_t;

	aod_st_t st_r, st_nxt;
	aod_pkg::aod_op_t op_p_r, op_nxt, op_r;
	aod_pkg::aod_form_t form_p_r, form_nxt, form_r;
	aod_pkg::aod_grp_t grp_p_r, grp_nxt;
	aod_pkg::aod_seg_t seg_p_r, seg_nxt, seg_r;
	logic w_p_r, w_nxt, d_p_r, d_nxt, m_p_r, m_nxt;
	logic two_p_r, two_nxt, itwo_p_r, itwo_nxt;
	logic [2:0] sel_p_r, sel_nxt, rm_p_r, rm_nxt;
	logic [15:0] imm_p_r, imm_nxt;
	logic [7:0] clk_p_r, clk_nxt, cnt_r;
	logic q_ready_r, done_r, width_r, dir_r, mem_r, seg_valid_r, seg_arm_r, writes_r, bad_r;
	logic [2:0] sel_r, rm_r;
	logic [15:0] imm_r;
	logic [7:0] clocks_r, xw;
	logic take, fin, last;

	// Selector shared by the two-operand and immediate families
	function automatic aod_pkg::aod_op_t alu_op(input logic [2:0] s);
		if (s == aod_pkg::SEL_SUM) alu_op = aod_pkg::OP_SUM;
		else if (s == aod_pkg::SEL_CSUM) alu_op = aod_pkg::OP_CSUM;
		else if (s == aod_pkg::SEL_BDIFF) alu_op = aod_pkg::OP_BDIFF;
		else if (s == aod_pkg::SEL_DIFF) alu_op = aod_pkg::OP_DIFF;
		else if (s == aod_pkg::SEL_COMPARE) alu_op = aod_pkg::OP_COMPARE;
		else alu_op = aod_pkg::OP_NONE;
	endfunction : alu_op

	// Clock count of a finished decode
	function automatic logic [7:0] calc(input aod_pkg::aod_op_t o, input aod_pkg::aod_form_t f,
		input logic m, input logic w);
		logic [7:0] c;
		c = aod_pkg::C_BAD;
		case (o)
			aod_pkg::OP_SEG: c = aod_pkg::C_PFX;
			aod_pkg::OP_AFIX_S: c = aod_pkg::C_ASUM;
			aod_pkg::OP_BFIX_S: c = aod_pkg::C_BSUM;
			aod_pkg::OP_AFIX_D: c = aod_pkg::C_ADIF;
			aod_pkg::OP_BFIX_D: c = aod_pkg::C_BDIF;
			aod_pkg::OP_SUM, aod_pkg::OP_CSUM, aod_pkg::OP_DIFF, aod_pkg::OP_BDIFF, aod_pkg::OP_COMPARE: begin
				if (f == aod_pkg::F_ACC) c = w ? aod_pkg::C_AW : aod_pkg::C_AB;
				else if (f == aod_pkg::F_IMM && o != aod_pkg::OP_COMPARE) c = m ? aod_pkg::C_IM : aod_pkg::C_IR;
				else c = m ? aod_pkg::C_RM : aod_pkg::C_RR;
			end
			aod_pkg::OP_UP, aod_pkg::OP_DOWN: begin
				c = m ? aod_pkg::C_STEP_M : aod_pkg::C_STEP_R;
			end
			aod_pkg::OP_SIGN: begin
				c = m ? aod_pkg::C_RM : aod_pkg::C_RR;
			end
			aod_pkg::OP_PROD: begin
				if (m) c = w ? aod_pkg::C_PMW : aod_pkg::C_PMB;
				else c = w ? aod_pkg::C_PRW : aod_pkg::C_PRB;
			end
			default: c = aod_pkg::C_BAD;
		endcase
		if (NARROW_BUS && w && m && o != aod_pkg::OP_NONE) c = c + aod_pkg::C_WX;
		calc = c;
	endfunction : calc

	// Ready is only ever high outside execution
	assign take = q_valid && q_ready_r;

	// Next decode state and pending fields
	always_comb begin
		st_nxt = st_r;
		op_nxt = op_p_r;
		form_nxt = form_p_r;
		grp_nxt = grp_p_r;
		seg_nxt = seg_p_r;
		w_nxt = w_p_r;
		d_nxt = d_p_r;
		m_nxt = m_p_r;
		two_nxt = two_p_r;
		itwo_nxt = itwo_p_r;
		sel_nxt = sel_p_r;
		rm_nxt = rm_p_r;
		imm_nxt = imm_p_r;
		fin = 1'b0;
		last = 1'b0;
		case (st_r)
			ST_OPC: begin
				if (take) begin
					op_nxt = aod_pkg::OP_NONE;
					form_nxt = aod_pkg::F_NONE;
					grp_nxt = aod_pkg::G_ALU;
					w_nxt = q_byte[0];
					d_nxt = q_byte[1];
					m_nxt = 1'b0;
					two_nxt = 1'b0;
					itwo_nxt = 1'b0;
					sel_nxt = 3'h0;
					rm_nxt = 3'h0;
					imm_nxt = 16'h0000;
					if (q_byte == aod_pkg::PFX_CODE || q_byte == aod_pkg::PFX_STACK ||
						q_byte == aod_pkg::PFX_DATA || q_byte == aod_pkg::PFX_EXTRA) begin
						op_nxt = aod_pkg::OP_SEG;
						seg_nxt = (q_byte == aod_pkg::PFX_CODE) ? aod_pkg::SEG_CODE :
							(q_byte == aod_pkg::PFX_STACK) ? aod_pkg::SEG_STACK :
							(q_byte == aod_pkg::PFX_DATA) ? aod_pkg::SEG_DATA : aod_pkg::SEG_EXTRA;
						fin = 1'b1;
					end else if (q_byte == aod_pkg::FIX_ASCII_SUM) begin
						op_nxt = aod_pkg::OP_AFIX_S;
						fin = 1'b1;
					end else if (q_byte == aod_pkg::FIX_BCD_SUM) begin
						op_nxt = aod_pkg::OP_BFIX_S;
						fin = 1'b1;
					end else if (q_byte == aod_pkg::FIX_ASCII_DIF) begin
						op_nxt = aod_pkg::OP_AFIX_D;
						fin = 1'b1;
					end else if (q_byte == aod_pkg::FIX_BCD_DIF) begin
						op_nxt = aod_pkg::OP_BFIX_D;
						fin = 1'b1;
					end else if (q_byte[7:4] == aod_pkg::SHORT_STEP) begin
						op_nxt = q_byte[3] ? aod_pkg::OP_DOWN : aod_pkg::OP_UP;
						form_nxt = aod_pkg::F_ONE;
						w_nxt = 1'b1;
						d_nxt = 1'b0;
						rm_nxt = q_byte[2:0];
						fin = 1'b1;
					end else if (q_byte[7:6] == 2'h0 && !q_byte[2] && alu_op(q_byte[5:3]) != aod_pkg::OP_NONE) begin
						op_nxt = alu_op(q_byte[5:3]);
						form_nxt = aod_pkg::F_RM;
						st_nxt = ST_MODRM;
					end else if (q_byte[7:6] == 2'h0 && q_byte[2:1] == 2'h2 &&
						alu_op(q_byte[5:3]) != aod_pkg::OP_NONE) begin
						op_nxt = alu_op(q_byte[5:3]);
						form_nxt = aod_pkg::F_ACC;
						d_nxt = 1'b0;
						itwo_nxt = q_byte[0];
						st_nxt = ST_ILO;
					end else if (q_byte[7:2] == aod_pkg::IMM_GRP) begin
						form_nxt = aod_pkg::F_IMM;
						grp_nxt = aod_pkg::G_IMM;
						st_nxt = ST_MODRM;
					end else if (q_byte[7:1] == aod_pkg::UNARY_GRP) begin
						form_nxt = aod_pkg::F_RM;
						grp_nxt = aod_pkg::G_UNARY;
						st_nxt = ST_MODRM;
					end else if (q_byte[7:1] == aod_pkg::STEP_GRP) begin
						form_nxt = aod_pkg::F_RM;
						grp_nxt = aod_pkg::G_STEP;
						st_nxt = ST_MODRM;
					end else begin
						fin = 1'b1;
					end
				end
			end
			ST_MODRM: begin
				if (take) begin
					m_nxt = q_byte[7:6] != aod_pkg::MOD_REG;
					sel_nxt = q_byte[5:3];
					rm_nxt = q_byte[2:0];
					two_nxt = q_byte[7:6] == aod_pkg::MOD_D16 ||
						(q_byte[7:6] == aod_pkg::MOD_IND && q_byte[2:0] == aod_pkg::RM_DIRECT);
					if (grp_p_r == aod_pkg::G_IMM) begin
						op_nxt = alu_op(q_byte[5:3]);
						itwo_nxt = !d_p_r && w_p_r;
					end else if (grp_p_r == aod_pkg::G_UNARY) begin
						op_nxt = (q_byte[5:3] == aod_pkg::SEL_SIGN) ? aod_pkg::OP_SIGN :
							(q_byte[5:3] == aod_pkg::SEL_PROD) ? aod_pkg::OP_PROD : aod_pkg::OP_NONE;
					end else if (grp_p_r == aod_pkg::G_STEP) begin
						op_nxt = (q_byte[5:3] == aod_pkg::SEL_UP) ? aod_pkg::OP_UP :
							(q_byte[5:3] == aod_pkg::SEL_DOWN) ? aod_pkg::OP_DOWN : aod_pkg::OP_NONE;
					end
					if (q_byte[7:6] == aod_pkg::MOD_D8 || two_nxt) st_nxt = ST_DLO;
					else last = 1'b1;
				end
			end
			ST_DLO: begin
				if (take) begin
					if (two_p_r) st_nxt = ST_DHI;
					else last = 1'b1;
				end
			end
			ST_DHI: begin
				if (take) last = 1'b1;
			end
			ST_ILO: begin
				if (take) begin
					imm_nxt = (form_p_r == aod_pkg::F_IMM && d_p_r) ? {{8{q_byte[7]}}, q_byte} : {8'h00, q_byte};
					if (itwo_p_r) st_nxt = ST_IHI;
					else fin = 1'b1;
				end
			end
			ST_IHI: begin
				if (take) begin
					imm_nxt = {q_byte, imm_p_r[7:0]};
					fin = 1'b1;
				end
			end
			default: begin
				if (cnt_r == 8'h00) st_nxt = ST_OPC;
			end
		endcase
		// Displacement done: immediates follow only in the immediate family
		if (last) begin
			if (grp_p_r == aod_pkg::G_IMM) st_nxt = ST_ILO;
			else fin = 1'b1;
		end
		if (fin) st_nxt = ST_EXEC;
		clk_nxt = calc(op_nxt, form_nxt, m_nxt, w_nxt);
	end

	// Sequencer and execution countdown
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= ST_OPC;
			q_ready_r <= 1'b0;
			cnt_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			q_ready_r <= st_nxt != ST_EXEC;
			// Count lands so done shows N clocks after the last byte
			if (fin) cnt_r <= clk_nxt - aod_pkg::C_MIN;
			else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
		end
	end

	// Fields of the instruction being decoded
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			op_p_r <= aod_pkg::OP_NONE;
			form_p_r <= aod_pkg::F_NONE;
			grp_p_r <= aod_pkg::G_ALU;
			seg_p_r <= aod_pkg::SEG_CODE;
			w_p_r <= 1'b0;
			d_p_r <= 1'b0;
			m_p_r <= 1'b0;
			two_p_r <= 1'b0;
			itwo_p_r <= 1'b0;
			sel_p_r <= 3'h0;
			rm_p_r <= 3'h0;
			imm_p_r <= 16'h0000;
			clk_p_r <= 8'h00;
		end else begin
			op_p_r <= op_nxt;
			form_p_r <= form_nxt;
			grp_p_r <= grp_nxt;
			seg_p_r <= seg_nxt;
			w_p_r <= w_nxt;
			d_p_r <= d_nxt;
			m_p_r <= m_nxt;
			two_p_r <= two_nxt;
			itwo_p_r <= itwo_nxt;
			sel_p_r <= sel_nxt;
			rm_p_r <= rm_nxt;
			imm_p_r <= imm_nxt;
			if (fin) clk_p_r <= clk_nxt;
		end
	end

	// Result presented when execution time has run out
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			done_r <= 1'b0;
			bad_r <= 1'b0;
			op_r <= aod_pkg::OP_NONE;
			form_r <= aod_pkg::F_NONE;
			width_r <= 1'b0;
			dir_r <= 1'b0;
			mem_r <= 1'b0;
			sel_r <= 3'h0;
			rm_r <= 3'h0;
			imm_r <= 16'h0000;
			clocks_r <= 8'h00;
			writes_r <= 1'b0;
		end else begin
			done_r <= st_r == ST_EXEC && cnt_r == 8'h00;
			bad_r <= st_r == ST_EXEC && cnt_r == 8'h00 && op_p_r == aod_pkg::OP_NONE;
			if (st_r == ST_EXEC && cnt_r == 8'h00) begin
				op_r <= op_p_r;
				form_r <= form_p_r;
				width_r <= w_p_r;
				dir_r <= d_p_r;
				mem_r <= m_p_r;
				sel_r <= sel_p_r;
				rm_r <= rm_p_r;
				imm_r <= imm_p_r;
				clocks_r <= clk_p_r;
				writes_r <= op_p_r != aod_pkg::OP_NONE && op_p_r != aod_pkg::OP_SEG && op_p_r != aod_pkg::OP_COMPARE;
			end
		end
	end

	// Override is armed by a prefix and spent by the next instruction
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			seg_arm_r <= 1'b0;
			seg_valid_r <= 1'b0;
			seg_r <= aod_pkg::SEG_CODE;
		end else if (st_r == ST_EXEC && cnt_r == 8'h00) begin
			if (op_p_r == aod_pkg::OP_SEG) begin
				seg_arm_r <= 1'b1;
				seg_valid_r <= 1'b1;
				seg_r <= seg_p_r;
			end else begin
				seg_arm_r <= 1'b0;
				seg_valid_r <= seg_arm_r;
			end
		end
	end

	assign q_ready = q_ready_r;
	assign done = done_r;
	assign op = op_r;
	assign form = form_r;
	assign width = width_r;
	assign dir_s = dir_r;
	assign mem = mem_r;
	assign sel = sel_r;
	assign rm = rm_r;
	assign imm = imm_r;
	assign clocks = clocks_r;
	assign seg_valid = seg_valid_r;
	assign seg = seg_r;
	assign writes = writes_r;
	assign bad = bad_r;

	// Narrow-bus penalty the checks expect
	assign xw = (NARROW_BUS && width_r && mem_r) ? aod_pkg::C_WX : 8'h00;

	seg_prefix_a: assert property (@(posedge clock) disable iff (!arst_n)
		st_r == ST_OPC && take && q_byte == aod_pkg::PFX_DATA |->
		##2 done_r && op_r == aod_pkg::OP_SEG && seg_r == aod_pkg::SEG_DATA)
		else $error("data prefix not finished in 2 clocks");
	sum_clocks_a: assert property (@(posedge clock) disable iff (!arst_n)
		done_r && op_r == aod_pkg::OP_SUM && form_r == aod_pkg::F_RM |->
		clocks_r == (mem_r ? aod_pkg::C_RM + xw : aod_pkg::C_RR))
		else $error("sum count wrong");
	carry_imm_a: assert property (@(posedge clock) disable iff (!arst_n)
		done_r && op_r == aod_pkg::OP_CSUM && form_r == aod_pkg::F_IMM |->
		sel_r == aod_pkg::SEL_CSUM && clocks_r == (mem_r ? aod_pkg::C_IM + xw : aod_pkg::C_IR))
		else $error("carry sum immediate wrong");
	diff_acc_a: assert property (@(posedge clock) disable iff (!arst_n)
		done_r && op_r == aod_pkg::OP_DIFF && form_r == aod_pkg::F_ACC |->
		writes_r && clocks_r == (width_r ? aod_pkg::C_AW : aod_pkg::C_AB))
		else $error("difference accumulator count wrong");
	borrow_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
		done_r && form_r == aod_pkg::F_IMM && sel_r == aod_pkg::SEL_BDIFF |-> op_r == aod_pkg::OP_BDIFF)
		else $error("selector 011 not borrow difference");
	prod_clocks_a: assert property (@(posedge clock) disable iff (!arst_n)
		done_r && op_r == aod_pkg::OP_PROD |-> clocks_r == (mem_r ?
		(width_r ? aod_pkg::C_PMW + xw : aod_pkg::C_PMB) : (width_r ? aod_pkg::C_PRW : aod_pkg::C_PRB)))
		else $error("product count wrong");
	sign_clocks_a: assert property (@(posedge clock) disable iff (!arst_n)
		done_r && op_r == aod_pkg::OP_SIGN |->
		sel_r == aod_pkg::SEL_SIGN && clocks_r == (mem_r ? aod_pkg::C_RM + xw : aod_pkg::C_RR))
		else $error("sign change wrong");
	ascii_sum_a: assert property (@(posedge clock) disable iff (!arst_n)
		st_r == ST_OPC && take && q_byte == aod_pkg::FIX_ASCII_SUM |=>
		!done_r [*7] ##1 done_r && op_r == aod_pkg::OP_AFIX_S)
		else $error("ascii sum fixup not 8 clocks");
	bcd_sum_a: assert property (@(posedge clock) disable iff (!arst_n)
		st_r == ST_OPC && take && q_byte == aod_pkg::FIX_BCD_SUM |-> ##4 done_r && op_r == aod_pkg::OP_BFIX_S)
		else $error("bcd sum fixup not 4 clocks");
	ascii_dif_a: assert property (@(posedge clock) disable iff (!arst_n)
		st_r == ST_OPC && take && q_byte == aod_pkg::FIX_ASCII_DIF |-> ##7 done_r && op_r == aod_pkg::OP_AFIX_D)
		else $error("ascii difference fixup not 7 clocks");
	bcd_dif_a: assert property (@(posedge clock) disable iff (!arst_n)
		st_r == ST_OPC && take && q_byte == aod_pkg::FIX_BCD_DIF |-> ##4 done_r && op_r == aod_pkg::OP_BFIX_D)
		else $error("bcd difference fixup not 4 clocks");
	step_word_a: assert property (@(posedge clock) disable iff (!arst_n)
		done_r && op_r == aod_pkg::OP_UP && form_r == aod_pkg::F_RM && mem_r |->
		clocks_r == aod_pkg::C_STEP_M + xw)
		else $error("step memory count wrong");
	imm_single_a: assert property (@(posedge clock) disable iff (!arst_n)
		st_r == ST_ILO && take && form_p_r == aod_pkg::F_IMM && (d_p_r || !w_p_r) |=>
		st_r == ST_EXEC && (!d_p_r || imm_p_r[15:8] == {8{imm_p_r[7]}}))
		else $error("single immediate byte mishandled");
	imm_pair_a: assert property (@(posedge clock) disable iff (!arst_n)
		st_r == ST_ILO && take && form_p_r == aod_pkg::F_IMM && !d_p_r && w_p_r |=> st_r == ST_IHI)
		else $error("second immediate byte not fetched");
	short_down_a: assert property (@(posedge clock) disable iff (!arst_n)
		st_r == ST_OPC && take && q_byte[7:3] == 5'h09 |->
		##3 done_r && op_r == aod_pkg::OP_DOWN && clocks_r == aod_pkg::C_STEP_R)
		else $error("short step down wrong");
	compare_wb_a: assert property (@(posedge clock) disable iff (!arst_n)
		done_r && op_r == aod_pkg::OP_COMPARE |-> !writes_r)
		else $error("compare wrote back");

endmodule : aod_decoder

// ---- verification/aod_queue_model.sv ----
// Prefetch queue stand-in that offers bytes to the decoder
`timescale 1ns/10ps
module aod_queue_model (
	input wire logic clock, // Processor clock
	input wire logic arst_n, // Asynchronous reset
	input wire logic q_ready, // Decoder takes the byte
	input wire logic slow, // Leave an idle cycle after each take
	output logic q_valid, // Byte on offer
	output logic [7:0] q_byte // Offered byte
);
	logic [7:0] fifo[$];
	logic took;
	initial begin
		q_valid = 1'b0;
		q_byte = 8'hA5;
		took = 1'b0;
	end
	// Note whether the offer was taken at this edge
	always @(posedge clock) took = q_valid && q_ready;
	// An offer holds until taken; a released line never shows the stale byte
	always @(negedge clock) begin
		if (took) begin
			void'(fifo.pop_front());
			q_valid = 1'b0;
			q_byte = ~q_byte;
		end
		if (!q_valid && fifo.size() > 0 && arst_n && !(slow && took)) begin
			q_valid = 1'b1;
			q_byte = fifo[0];
		end
	end
	task push(input logic [7:0] b);
		fifo.push_back(b);
	endtask : push
endmodule : aod_queue_model

// ---- verification/tb_arith_opcode_decoder.sv ----
// Self-checking bench for the arithmetic opcode decoder
`timescale 1ns/10ps
module tb_arith_opcode_decoder;
	logic clock, arst_n, slow;
	logic q_valid, q_ready, done, width, dir_s, mem, seg_valid, writes, bad;
	logic [7:0] q_byte, clocks, q_byte_n, clocks_n;
	logic [2:0] sel, rm;
	logic [15:0] imm;
	logic q_valid_n, q_ready_n, done_n;
	aod_pkg::aod_op_t op;
	aod_pkg::aod_form_t form;
	aod_pkg::aod_seg_t seg;
	int cyc, tk, tkn, miscompares, total_checks;

	aod_queue_model q (.clock(clock), .arst_n(arst_n), .q_ready(q_ready), .slow(slow), .q_valid(q_valid),
		.q_byte(q_byte));
	aod_decoder dut (.clock(clock), .arst_n(arst_n), .q_valid(q_valid), .q_byte(q_byte), .q_ready(q_ready),
		.done(done), .op(op), .form(form), .width(width), .dir_s(dir_s), .mem(mem), .sel(sel), .rm(rm),
		.imm(imm), .clocks(clocks), .seg_valid(seg_valid), .seg(seg), .writes(writes), .bad(bad));
	// Narrow bus copy, fed by its own queue
	aod_queue_model qn (.clock(clock), .arst_n(arst_n), .q_ready(q_ready_n), .slow(1'b0),
		.q_valid(q_valid_n), .q_byte(q_byte_n));
	aod_decoder #(.NARROW_BUS(1'b1)) dut_n (.clock(clock), .arst_n(arst_n), .q_valid(q_valid_n),
		.q_byte(q_byte_n), .q_ready(q_ready_n), .done(done_n), .op(), .form(), .width(), .dir_s(), .mem(),
		.sel(), .rm(), .imm(), .clocks(clocks_n), .seg_valid(), .seg(), .writes(), .bad());

	// Clock at 20 MHz
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Edge count and the edge of the latest take on each queue
	always @(posedge clock) begin
		cyc++;
		if (q_valid && q_ready) tk = cyc;
		if (q_valid_n && q_ready_n) tkn = cyc;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_cyc(input int got, input int exp);
		total_checks++;
		if (got != exp) begin
			miscompares++;
			$display("wrong value at %0t: done after %0d cycles, expected %0d", $time, got, exp);
		end
	endtask : chk_cyc
	// Offer n bytes, first byte lowest, then judge the finished instruction
	task automatic run(input bit nb, input logic [47:0] bs, input int n, input aod_pkg::aod_op_t eo,
		input logic [7:0] ec);
		int k;
		for (k = 0; k < n; k++) if (nb) qn.push(bs[8*k +: 8]); else q.push(bs[8*k +: 8]);
		k = 0;
		@(negedge clock);
		while ((nb ? done_n : done) !== 1'b1 && k < 200) begin
			@(negedge clock);
			k++;
		end
		// Done seen here is sampled at the next rising edge; a run-out counts as a mismatch
		if (k >= 200) miscompares++;
		chk_cyc(cyc + 1 - (nb ? tkn : tk), ec);
		chk(nb ? clocks_n : clocks, ec);
		if (!nb) begin
			chk(op, eo);
			chk(bad, eo == aod_pkg::OP_NONE);
			chk(writes, !(eo inside {aod_pkg::OP_COMPARE, aod_pkg::OP_SEG, aod_pkg::OP_NONE}));
		end
	endtask : run

	task automatic t_prefix;
		logic [7:0] pfx[4];
		int i;
		pfx = '{8'h2E, 8'h36, 8'h3E, 8'h26};
		for (i = 0; i < 4; i++) begin
			run(0, pfx[i], 1, aod_pkg::OP_SEG, 8'h02);
			chk(seg, i);
			chk(seg_valid, 1'b1);
		end
		run(0, 48'hC001, 2, aod_pkg::OP_SUM, 8'h03);
		chk(seg_valid, 1'b1);
		chk(seg, 16'h0003);
		run(0, 48'h27, 1, aod_pkg::OP_BFIX_S, 8'h04);
		chk(seg_valid, 1'b0);
	endtask : t_prefix
	task automatic t_alu;
		logic [7:0] opc[5];
		aod_pkg::aod_op_t ops[5];
		int i;
		opc = '{8'h01, 8'h11, 8'h29, 8'h19, 8'h39};
		ops = '{aod_pkg::OP_SUM, aod_pkg::OP_CSUM, aod_pkg::OP_DIFF, aod_pkg::OP_BDIFF, aod_pkg::OP_COMPARE};
		for (i = 0; i < 5; i++) begin
			run(0, {8'hD8, opc[i]}, 2, ops[i], 8'h03);
			chk(mem, 1'b0);
			run(0, {8'h12, 8'h34, 8'h1E, opc[i] | 8'h02}, 4, ops[i], 8'h0A);
			chk(mem, 1'b1);
			run(0, {8'h12, 8'h34, opc[i] + 8'h04}, 3, ops[i], 8'h04);
			chk(imm, 16'h1234);
			run(0, {8'h7F, opc[i] + 8'h03}, 2, ops[i], 8'h03);
		end
	endtask : t_alu
	task automatic t_imm;
		run(0, 48'hFFC083, 3, aod_pkg::OP_SUM, 8'h04);
		chk(imm, 16'hFFFF);
		chk({form, sel, width, dir_s}, {aod_pkg::F_IMM, 3'h0, 2'h3});
		run(0, 48'h1234D081, 4, aod_pkg::OP_CSUM, 8'h04);
		chk(imm, 16'h1234);
		run(0, 48'h80E880, 3, aod_pkg::OP_DIFF, 8'h04);
		chk(imm, 16'h0080);
		chk({sel, width, dir_s}, {aod_pkg::SEL_DIFF, 2'h0});
		run(0, 48'h80D883, 3, aod_pkg::OP_BDIFF, 8'h04);
		chk(imm, 16'hFF80);
		slow = 1'b1;
		run(0, 48'h123410001681, 6, aod_pkg::OP_CSUM, 8'h10);
		chk(imm, 16'h1234);
		slow = 1'b0;
	endtask : t_imm
	task automatic t_unary;
		run(0, 48'hE0F6, 2, aod_pkg::OP_PROD, 8'h1C);
		run(0, 48'hE0F7, 2, aod_pkg::OP_PROD, 8'h25);
		run(0, 48'h100026F6, 4, aod_pkg::OP_PROD, 8'h22);
		run(0, 48'h100026F7, 4, aod_pkg::OP_PROD, 8'h2B);
		run(0, 48'hD8F6, 2, aod_pkg::OP_SIGN, 8'h03);
		run(0, 48'h10001EF7, 4, aod_pkg::OP_SIGN, 8'h0A);
		run(0, 48'hF0F6, 2, aod_pkg::OP_NONE, 8'h02);
	endtask : t_unary
	task automatic t_fix;
		run(0, 48'h37, 1, aod_pkg::OP_AFIX_S, 8'h08);
		run(0, 48'h27, 1, aod_pkg::OP_BFIX_S, 8'h04);
		run(0, 48'h3F, 1, aod_pkg::OP_AFIX_D, 8'h07);
		run(0, 48'h2F, 1, aod_pkg::OP_BFIX_D, 8'h04);
		run(0, 48'h90, 1, aod_pkg::OP_NONE, 8'h02);
	endtask : t_fix
	task automatic t_step;
		run(0, 48'hC0FE, 2, aod_pkg::OP_UP, 8'h03);
		run(0, 48'hC9FF, 2, aod_pkg::OP_DOWN, 8'h03);
		run(0, 48'h40, 1, aod_pkg::OP_UP, 8'h03);
		chk(form, aod_pkg::F_ONE);
		run(0, 48'h4B, 1, aod_pkg::OP_DOWN, 8'h03);
		chk(rm, 16'h0003);
		run(0, 48'h100006FF, 4, aod_pkg::OP_UP, 8'h0F);
	endtask : t_step
	// Word memory operands cost four more on the narrow bus, nothing else does
	task automatic t_narrow;
		run(1, 48'h100026F7, 4, aod_pkg::OP_PROD, 8'h2F);
		run(1, 48'h100026F6, 4, aod_pkg::OP_PROD, 8'h22);
		run(1, 48'h123410001681, 6, aod_pkg::OP_CSUM, 8'h14);
		run(1, 48'h123405, 3, aod_pkg::OP_SUM, 8'h04);
		run(1, 48'h100006FF, 4, aod_pkg::OP_UP, 8'h13);
	endtask : t_narrow

	task end_sim;
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		arst_n = 1'b0;
		slow = 1'b0;
		{cyc, tk, tkn, miscompares, total_checks} = '0;
		repeat (12) @(negedge clock);
		arst_n = 1'b1;
		t_prefix;
		t_alu;
		t_imm;
		t_unary;
		t_fix;
		t_step;
		t_narrow;
		end_sim;
	end
	// Watchdog: the tests need well under a tenth of this
	initial begin
		#1000000;
		miscompares++;
		end_sim;
	end
endmodule : tb_arith_opcode_decoder
